// ==== hw/asr_pkg.sv ====
// Package for the asynchronous static memory host controller
package asr_pkg;
	localparam int ADDR_W   = 15;
	localparam int DATA_W   = 8;
	localparam int CLK_MHZ  = 100;
	// Access phase timing at 100 MHz
	localparam int ADDR_SETUP_CYC = 1;
	localparam int WRITE_PULSE_NS = 70;
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int READ_ACCESS_NS = 90;
	localparam int READ_ACCESS_CYC = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
	localparam int TURN_CYC = 4;
	// Recovery after retention, minimum
	localparam int RECOVERY_MS = 5;
	localparam int RECOVERY_CYC = RECOVERY_MS * CLK_MHZ * 1000;
	localparam logic [3:0] COUNT_RESET = 4'h0;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SETUP  = 3'b001,
		ST_WRITE  = 3'b010,
		ST_READ   = 3'b011,
		ST_TURN   = 3'b100,
		ST_RETAIN = 3'b101,
		ST_RECOV  = 3'b110
	} asr_state_type;

	// Memory pin group driven by the host
	typedef struct packed {
		logic [ADDR_W-1:0] address_lines;
		logic              select_active_low_n;
		logic              select_active_high;
		logic              write_strobe_n;
	} asr_pins_type;

	// User request
	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} asr_req_type;
endpackage : asr_pkg

// ==== hw/asr_host.sv ====
// Host controller for an asynchronous 32K x 8 static memory
// Summary of operation
// [R1] Address changes only while deselected
// [R2] Write only when all three strobes overlap
// [R3] Select after strobe falls keeps pins undriven
// [R4] Strobe low means memory never drives
// [R5] Strobe high and selected reads data
// [R6] Host drives data only while strobe low; the code keeps driving for the first ST_TURN cycle after strobe rises
// [R7] Deselect at retention, wait 5 ms after
// [R8] High select held at firm rail level
// [R9] Retention by low select may float pins
// [R10] Retention by high select may float others
// [R11] Strobe stays high through read cycles
// [R12] Deselected memory ignores strobe, stays undriven
`timescale 1ns/1ps
`default_nettype none
module asr_host #(
	parameter int RECOVERY_CYCLES = asr_pkg::RECOVERY_CYC
) (
	input  wire logic                       clk_in,
	input  wire logic                       reset_n_in,
	input  wire logic                       req_valid_in,
	input  wire asr_pkg::asr_req_type       req_in,
	output logic                            req_ready_out,
	output logic                            rdata_valid_out,
	output logic [asr_pkg::DATA_W-1:0]      rdata_out,
	input  wire logic                       retain_in,
	output logic                            retained_out,
	output asr_pkg::asr_pins_type           pins_out,
	output logic                            pins_oe_n_out,
	output logic [asr_pkg::DATA_W-1:0]      data_lines_out,
	output logic                            data_lines_oe_n_out,
	input  wire logic [asr_pkg::DATA_W-1:0] data_lines_in
);
	asr_pkg::asr_state_type state, next_state;
	logic [31:0]                 count, next_count;
	asr_pkg::asr_pins_type       pins, next_pins;
	logic                        is_write, next_is_write;
	logic [asr_pkg::DATA_W-1:0]  wdata, next_wdata;
	logic [asr_pkg::DATA_W-1:0]  rdata, next_rdata;
	logic                        rvalid, next_rvalid;
	logic                        float_pins, next_float_pins;
	logic                        drive_data, next_drive_data;
	logic [asr_pkg::DATA_W-1:0]  sync1, sync2;

	// Two-stage synchroniser on the data pins; memory output is async to us
	always_ff @(posedge clk_in) begin
		sync1 <= data_lines_in;
		sync2 <= sync1;
	end

	// Sequencer: next values
	always_comb begin
		next_state      = state;
		next_count      = count;
		next_pins       = pins;
		next_is_write   = is_write;
		next_wdata      = wdata;
		next_rdata      = rdata;
		next_rvalid     = 1'b0;
		next_float_pins = float_pins;
		next_drive_data = drive_data;
		case (state)
			asr_pkg::ST_IDLE: begin
				if (retain_in) begin
					// Deselect by high select low, others may float [R7] [R10]
					next_pins.select_active_high  = 1'b0; // [R8]
					next_pins.select_active_low_n = 1'b1;
					next_pins.write_strobe_n      = 1'b1;
					next_float_pins               = 1'b1;
					next_state                    = asr_pkg::ST_RETAIN;
				end else if (req_valid_in) begin
					// Address moves only while deselected [R1]
					next_pins.address_lines = req_in.addr;
					next_is_write = req_in.write;
					next_wdata    = req_in.wdata;
					next_count    = 32'(asr_pkg::ADDR_SETUP_CYC);
					next_state    = asr_pkg::ST_SETUP;
				end
			end
			asr_pkg::ST_SETUP: begin
				if (count > 32'h1) begin
					next_count = count - 32'h1;
				end else if (is_write) begin
					// Strobe falls with select, memory stays undriven [R3] [R4]
					next_pins.write_strobe_n      = 1'b0;
					next_pins.select_active_low_n = 1'b0;
					next_pins.select_active_high  = 1'b1; // [R2]
					next_drive_data               = 1'b1; // [R6]
					next_count = 32'(asr_pkg::WRITE_PULSE_CYC);
					next_state = asr_pkg::ST_WRITE;
				end else begin
					// Strobe held high for a read [R11] [R5]
					next_pins.select_active_low_n = 1'b0;
					next_pins.select_active_high  = 1'b1;
					next_count = 32'(asr_pkg::READ_ACCESS_CYC) + 32'h2;
					next_state = asr_pkg::ST_READ;
				end
			end
			asr_pkg::ST_WRITE: begin
				if (count > 32'h1) begin
					next_count = count - 32'h1;
				end else begin
					// Strobe and select rise together; data held one more cycle
					next_pins.write_strobe_n      = 1'b1;
					next_pins.select_active_low_n = 1'b1; // [R12]
					next_count = 32'(asr_pkg::TURN_CYC);
					next_state = asr_pkg::ST_TURN;
				end
			end
			asr_pkg::ST_READ: begin
				if (count > 32'h1) begin
					next_count = count - 32'h1;
				end else begin
					next_rdata  = sync2;
					next_rvalid = 1'b1;
					next_pins.select_active_low_n = 1'b1;
					next_count = 32'(asr_pkg::TURN_CYC);
					next_state = asr_pkg::ST_TURN;
				end
			end
			asr_pkg::ST_TURN: begin
				next_drive_data = 1'b0; // [R6]
				if (count > 32'h1) begin
					next_count = count - 32'h1;
				end else begin
					next_state = asr_pkg::ST_IDLE;
				end
			end
			asr_pkg::ST_RETAIN: begin
				if (!retain_in) begin
					// Supply back: keep deselected, wait the recovery time [R7]
					next_float_pins = 1'b0;
					next_count      = 32'(RECOVERY_CYCLES);
					next_state      = asr_pkg::ST_RECOV;
				end
			end
			asr_pkg::ST_RECOV: begin
				if (count > 32'h1) begin
					next_count = count - 32'h1;
				end else begin
					next_state = asr_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = asr_pkg::ST_IDLE;
			end
		endcase
	end

	// Sequencer: registers
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			state      <= asr_pkg::ST_IDLE;
			count      <= 32'(asr_pkg::COUNT_RESET);
			pins       <= '{address_lines: '0, select_active_low_n: 1'b1,
			                select_active_high: 1'b0, write_strobe_n: 1'b1};
			is_write   <= 1'b0;
			wdata      <= '0;
			rdata      <= '0;
			rvalid     <= 1'b0;
			float_pins <= 1'b0;
			drive_data <= 1'b0;
		end else begin
			state      <= next_state;
			count      <= next_count;
			pins       <= next_pins;
			is_write   <= next_is_write;
			wdata      <= next_wdata;
			rdata      <= next_rdata;
			rvalid     <= next_rvalid;
			float_pins <= next_float_pins;
			drive_data <= next_drive_data;
		end
	end

	// Outputs; high select is never floated so it sits at a rail [R8] [R9]
	assign req_ready_out       = (state == asr_pkg::ST_IDLE) && !retain_in;
	assign rdata_valid_out     = rvalid;
	assign rdata_out           = rdata;
	assign retained_out        = (state == asr_pkg::ST_RETAIN);
	assign pins_out            = pins;
	assign pins_oe_n_out       = float_pins;
	assign data_lines_out      = wdata;
	assign data_lines_oe_n_out = !drive_data;

	// Checks
	a_addr_stable: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!pins_out.select_active_low_n && $past(!pins_out.select_active_low_n)
		|-> $stable(pins_out.address_lines)) // [R1]
		else $error("address moved while selected");
	a_data_only_strobe: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!data_lines_oe_n_out && pins_out.write_strobe_n |-> state == asr_pkg::ST_TURN) // [R6]
		else $error("host drives data outside write");
	a_read_strobe_high: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == asr_pkg::ST_READ |-> pins_out.write_strobe_n) // [R11]
		else $error("strobe low in read");
	a_write_overlap: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!pins_out.write_strobe_n |-> !pins_out.select_active_low_n
		&& pins_out.select_active_high && !data_lines_oe_n_out) // [R2]
		else $error("write strobe without select or data");
	a_retain_deselect: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == asr_pkg::ST_RETAIN |-> !pins_out.select_active_high) // [R7]
		else $error("selected during retention");
	a_recover_wait: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$rose(state == asr_pkg::ST_RECOV) |-> count == 32'(RECOVERY_CYCLES)) // [R7]
		else $error("recovery count wrong");
	a_recov_no_req: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		state == asr_pkg::ST_RECOV |-> !req_ready_out && pins_out.select_active_low_n) // [R7]
		else $error("access during recovery");
	a_write_len: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$fell(pins_out.write_strobe_n) |-> !pins_out.write_strobe_n [*7] ##1
		pins_out.write_strobe_n) // [R2]
		else $error("write pulse length wrong");
	c_write: cover property (@(posedge clk_in) $rose(pins_out.write_strobe_n));
	c_read: cover property (@(posedge clk_in) rdata_valid_out);
	c_retain: cover property (@(posedge clk_in) $fell(retained_out));
endmodule : asr_host
`default_nettype wire

// ==== bench/asr_mem_model.sv ====
// Behavioural model of the static memory facing the host controller
`timescale 1ns/1ps
`default_nettype none
module asr_mem_model (
	input  wire logic                       clk_in,
	input  wire asr_pkg::asr_pins_type      pins_in,
	input  wire logic                       pins_oe_n_in,
	input  wire logic [asr_pkg::DATA_W-1:0] host_data_in,
	input  wire logic                       host_oe_n_in,
	output logic [asr_pkg::DATA_W-1:0]      data_out,
	output logic                            driving_out
);
	logic [asr_pkg::DATA_W-1:0] mem [0:(1<<asr_pkg::ADDR_W)-1];
	logic [asr_pkg::DATA_W-1:0] idle_pat = 8'h5A;
	logic                       sel;
	logic                       wr_ov;
	logic                       low_sel_n;
	logic [asr_pkg::ADDR_W-1:0] addr;
	// Floated low select and address show their inverse, so a stale level never helps;
	// only the high select held low may keep the memory idle then
	assign low_sel_n = pins_oe_n_in ? ~pins_in.select_active_low_n : pins_in.select_active_low_n;
	assign addr      = pins_oe_n_in ? ~pins_in.address_lines : pins_in.address_lines;
	assign sel = pins_in.select_active_high & ~low_sel_n;
	assign wr_ov = sel & ~pins_in.write_strobe_n;
	// Strobe low keeps the lines undriven, even if select came late
	assign driving_out = sel & pins_in.write_strobe_n;
	// Byte is taken when the overlap ends; undriven host data stores junk
	always @(negedge wr_ov) begin
		mem[addr] = host_oe_n_in ? ~host_data_in : host_data_in;
	end
	// Released lines wander every cycle so a stale value never reads right
	always @(posedge clk_in) begin
		idle_pat <= {idle_pat[6:0], ~idle_pat[7]};
	end
	assign data_out = driving_out ? mem[addr] : idle_pat;
endmodule : asr_mem_model
`default_nettype wire

// ==== bench/async_sram_write_and_retention_bench.sv ====
// Self-checking bench for the static memory host controller
`timescale 1ns/1ps
`default_nettype none
module async_sram_write_and_retention_bench;
	localparam int REC = 20;
	logic                       clk_in = 0, reset_n_in = 0, req_valid_in = 0, retain_in = 0;
	asr_pkg::asr_req_type       req_in = '0;
	logic                       req_ready_out, rdata_valid_out, retained_out, pins_oe_n_out;
	logic [7:0]                 rdata_out, data_lines_out, mem_data;
	logic                       data_lines_oe_n_out, drv;
	asr_pkg::asr_pins_type      pins_out;
	logic [14:0]                prev_a;
	int                         n_mismatch = 0, compares = 0;
	always #5 clk_in = ~clk_in;
	asr_host #(.RECOVERY_CYCLES(REC)) DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
		.rdata_valid_out(rdata_valid_out), .rdata_out(rdata_out), .retain_in(retain_in),
		.retained_out(retained_out), .pins_out(pins_out), .pins_oe_n_out(pins_oe_n_out),
		.data_lines_out(data_lines_out), .data_lines_oe_n_out(data_lines_oe_n_out),
		.data_lines_in(mem_data));
	asr_mem_model mem (.clk_in(clk_in), .pins_in(pins_out), .pins_oe_n_in(pins_oe_n_out),
		.host_data_in(data_lines_out), .host_oe_n_in(data_lines_oe_n_out),
		.data_out(mem_data), .driving_out(drv));
	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk
	task automatic stop_test();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : stop_test
	// Pins are judged mid-cycle, clear of the edge that updates them
	always @(negedge clk_in) begin
		prev_a <= pins_out.address_lines;
		if (reset_n_in) begin
			if (!data_lines_oe_n_out && drv) chk(0, "data line contention");
			if (pins_out.address_lines !== prev_a && !pins_out.select_active_low_n
				&& pins_out.select_active_high && !pins_out.write_strobe_n)
				chk(0, "address moved in write");
			if (!pins_out.write_strobe_n && data_lines_oe_n_out && !pins_oe_n_out)
				chk(0, "strobe low without data");
			if ($isunknown(pins_out.select_active_high)) chk(0, "high select not firm");
		end
	end
	task automatic wait_ready();
		int n;
		for (n = 0; n < 100 && req_ready_out !== 1'b1; n++) @(posedge clk_in) #1;
		if (n == 100) begin
			chk(0, "ready timeout");
			stop_test();
		end
	endtask : wait_ready
	task automatic do_req(input logic w, input logic [14:0] a, input logic [7:0] d);
		wait_ready();
		req_valid_in = 1;
		req_in = '{w, a, d};
		@(posedge clk_in) #1;
		req_valid_in = 0;
	endtask : do_req
	task automatic rd(input logic [14:0] a, input logic [7:0] exp);
		int n;
		do_req(0, a, 8'h00);
		for (n = 1; n < 40; n++) begin
			@(posedge clk_in) #1;
			if (rdata_valid_out === 1'b1) break;
		end
		// Take edge, one setup cycle, then eleven cycles in the read phase
		chk(n == 12, "read latency");
		chk(rdata_out === exp, "read data");
		if (n == 40) stop_test();
	endtask : rd
	// Retention with a refused write inside, then timed recovery
	task automatic retention();
		int n;
		wait_ready();
		retain_in = 1;
		@(posedge clk_in) #1;
		chk(retained_out === 1'b1 && pins_oe_n_out === 1'b1, "retention entry");
		chk(pins_out.select_active_high === 1'b0 && req_ready_out === 1'b0, "not deselected");
		req_valid_in = 1;
		req_in = '{1'b1, 15'h0001, 8'hFF};
		repeat (5) @(posedge clk_in) #1;
		req_valid_in = 0;
		chk(retained_out === 1'b1, "left retention");
		retain_in = 0;
		for (n = 0; n < 200 && req_ready_out !== 1'b1; n++) @(posedge clk_in) #1;
		chk(n >= REC && n < 200, "recovery wait");
		if (n == 200) stop_test();
	endtask : retention
	initial begin
		repeat (8) @(posedge clk_in);
		#1 reset_n_in = 1;
		do_req(1, 15'h0000, 8'h3C);
		do_req(1, 15'h7FFF, 8'hC3);
		rd(15'h0000, 8'h3C);
		rd(15'h7FFF, 8'hC3);
		do_req(1, 15'h0001, 8'h81);
		rd(15'h0001, 8'h81);
		retention();
		rd(15'h0000, 8'h3C);
		rd(15'h0001, 8'h81);
		stop_test();
	end
endmodule : async_sram_write_and_retention_bench
`default_nettype wire
